// ==== rtl/gate_drv_pkg.sv ====
package gate_drv_pkg;

    // Clock period in picoseconds (250 MHz)
    localparam int unsigned CLK_PERIOD_PS = 4000;

    // Input deglitch width, printed figure in ns
    localparam int unsigned INPUT_FILTER_NS = 40;
    // Least time, so round up
    localparam int unsigned INPUT_FILTER_CYC = (INPUT_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Leading-edge blanking after the gate goes high, in ns
    localparam int unsigned BLANKING_NS = 200;
    localparam int unsigned BLANKING_CYC = (BLANKING_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Encoder period: 400 kHz means 2500 ns
    localparam int unsigned ENC_FREQ_KHZ = 400;
    localparam int unsigned ENC_PERIOD_CYC = (1000000000 / ENC_FREQ_KHZ) / CLK_PERIOD_PS;

    // Encoder input range in millivolts and duty in tenths of a percent
    localparam int unsigned AIN_MIN_MV = 600;
    localparam int unsigned AIN_MAX_MV = 4500;
    localparam int unsigned DUTY_MAX_PERMILLE = 880;
    localparam int unsigned DUTY_MIN_PERMILLE = 100;
    localparam int unsigned PERMILLE_FULL = 1000;

    // Lockout deglitch width in cycles (plain default)
    localparam int unsigned LOCKOUT_DEGLITCH_CYC = 16;

    // Default mute and reset filter counts in cycles (plain defaults)
    localparam int unsigned FAULT_MUTE_CYC_DEF = 256;
    localparam int unsigned RESET_FILTER_CYC_DEF = 64;

    // Analog input word width (millivolts)
    localparam int unsigned AIN_W = 13;

    // Comparator results from the analog front end
    typedef struct packed {
        logic vcc_lockout;     // Input supply below its lockout threshold
        logic vdd_lockout;     // Output supply comparator, hysteresis applied upstream
        logic vdd_open;        // Output positive supply absent
        logic vee_open;        // Negative rail absent
        logic sense_a_trip;    // Sense voltage above the overcurrent threshold
        logic gate_below_clamp; // Gate below the clamp threshold
    } analog_status_t;

    // Output stage controls
    typedef struct packed {
        logic source_on;      // Pull-up stage on
        logic sink_hard;      // Full-strength pull-down
        logic sink_soft;      // Reduced soft turn-off pull-down
        logic hiz;            // Both stages released
    } gate_ctrl_t;

    // Fault handling states
    typedef enum logic [1:0] {
        FLT_IDLE,
        FLT_MUTE,
        FLT_WAIT_LOW,
        FLT_WAIT_RISE
    } fault_state_t;

endpackage : gate_drv_pkg

// ==== rtl/gate_drv_logic.sv ====
// What this block does
// - Gate low while either supply locked out
// - Output supply lockout 12V, 800mV hysteresis
// - Deglitch lockout comparators before acting
// - Power-good low in lockout, released otherwise
// - Encoder stopped and output low in lockout
// - Clamp only when off and gate low
// - Overcurrent fault when sense exceeds 9V
// - Sense node pulled low when output low
// - Charge current only after 200ns blanking
// - Fault turns off with soft current
// - Fault flag latched low, output held off
// - Reset requests ignored during mute interval
// - Long low after mute, release on rise
// - Long enable low disables, sink pulls gate
// - Duty 88% at 0.6V to 10% at 4.5V
// - Encoder at 400kHz; floating input near 10%
// - Output high only IN+ high, IN- low, enabled
// - Both inputs high: output low, clamp on
// - 40ns deglitch on both inputs and enable
`timescale 1ns/1ps
module gate_drv_logic #(
    parameter int unsigned FAULT_MUTE_CYC = gate_drv_pkg::FAULT_MUTE_CYC_DEF,
    parameter int unsigned RESET_FILTER_CYC = gate_drv_pkg::RESET_FILTER_CYC_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic pwm_noninv_in,
    input wire logic pwm_inv_in,
    input wire logic reset_enable_in,
    input wire gate_drv_pkg::analog_status_t analog_status,
    input wire logic [gate_drv_pkg::AIN_W-1:0] analog_sense_in,
    output gate_drv_pkg::gate_ctrl_t gate_ctrl,
    output logic gate_source_out,
    output logic gate_sink_out,
    output logic miller_clamp_pin,
    output logic miller_clamp_pin_oe_n,
    output logic sense_a_pulldown,
    output logic sense_a_charge_en,
    output logic fault_flag_n_o,
    output logic fault_flag_n_oe_n,
    output logic power_good_o,
    output logic power_good_oe_n,
    output logic encoded_pwm_out,
    output logic encoded_pwm_oe_n
);

    // Elaboration check: the interval counters are 16 bits wide
    if (FAULT_MUTE_CYC < 1 || FAULT_MUTE_CYC > 65535 ||
        RESET_FILTER_CYC < 1 || RESET_FILTER_CYC > 65535) begin : g_bad_counts
        $error("mute and reset filter counts must lie in 1..65535");
    end

    localparam int unsigned CW = 16;
    localparam logic [CW-1:0] MUTE_LAST = CW'(FAULT_MUTE_CYC - 1);
    localparam logic [CW-1:0] RFIL_LAST = CW'(RESET_FILTER_CYC - 1);
    localparam logic [7:0] INF_LAST = 8'(gate_drv_pkg::INPUT_FILTER_CYC - 1);
    localparam logic [7:0] LKO_LAST = 8'(gate_drv_pkg::LOCKOUT_DEGLITCH_CYC - 1);
    localparam logic [7:0] BLANK_LAST = 8'(gate_drv_pkg::BLANKING_CYC - 1);
    localparam logic [11:0] ENC_LAST = 12'(gate_drv_pkg::ENC_PERIOD_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Input deglitch for IN+, IN-, enable (index 0..2), lockouts (3..4) and open rails (5..6)

    logic [6:0] raw_in;       // Raw levels to be filtered
    logic [6:0] filt_reg;     // Filtered, accepted levels
    logic [6:0] filt_reset;   // Level each filter starts from
    assign raw_in = {analog_status.vee_open, analog_status.vdd_open,
                     analog_status.vdd_lockout, analog_status.vcc_lockout,
                     reset_enable_in, pwm_inv_in, pwm_noninv_in};
    // Lockouts start asserted, so the gate is off until supplies prove good;
    // open rails start clear so the stage is not released out of reset
    assign filt_reset = 7'h18;

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_filter
            logic [7:0] cnt_reg;   // Cycles the new level has held
            // Width depends on whether this is a pin or a lockout comparator
            localparam logic [7:0] LAST = (gi < 3) ? INF_LAST : LKO_LAST;
            // Level must stand for the whole width before it is taken
            // deglitch filter
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    cnt_reg <= 8'h00;
                    filt_reg[gi] <= filt_reset[gi];
                end else if (clk_en) begin
                    if (raw_in[gi] == filt_reg[gi]) begin
                        cnt_reg <= 8'h00;
                    end else if (cnt_reg >= LAST) begin
                        cnt_reg <= 8'h00;
                        filt_reg[gi] <= raw_in[gi];
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
            end
        end
    endgenerate

    logic in_pos, in_neg, en_f, lockout, rails_ok, vdd_open_f;
    assign in_pos = filt_reg[0];
    assign in_neg = filt_reg[1];
    assign en_f = filt_reg[2];
    // either supply locks out; threshold and hysteresis sit in the comparator
    assign lockout = filt_reg[3] | filt_reg[4];
    // an open rail is treated as a lockout too
    assign vdd_open_f = filt_reg[5];
    assign rails_ok = ~lockout & ~filt_reg[6] & ~vdd_open_f;

    ////////////////////////////////////////////////////////////////////////////
    // Enable low filter: longer than the reset filter time disables the driver

    logic [CW-1:0] low_cnt_reg;   // Cycles the enable has been low
    logic en_low_long_reg;        // Enable low beyond the filter time
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cnt_reg <= '0;
            en_low_long_reg <= 1'b1;
        end else if (clk_en) begin
            if (en_f) begin
                low_cnt_reg <= '0;
                en_low_long_reg <= 1'b0;
            end else if (low_cnt_reg >= RFIL_LAST) begin
                en_low_long_reg <= 1'b1;
            end else begin
                low_cnt_reg <= low_cnt_reg + 1'b1;
            end
        end
    end

    // Short low pulses past the deglitch still switch the gate off at once
    logic drive_on;
    // interlock: both inputs high keeps the gate low
    assign drive_on = rails_ok & en_f & ~en_low_long_reg & in_pos & ~in_neg;

    ////////////////////////////////////////////////////////////////////////////
    // Fault latch with mute interval and filtered reset

    gate_drv_pkg::fault_state_t fault_state_reg;  // Fault sequencer
    logic [CW-1:0] mute_cnt_reg;                  // Mute interval counter
    logic blank_done_reg;                         // Blanking over in this on-phase
    logic [CW-1:0] post_mute_low_reg;             // Low cycles counted after mute
    logic fault_trip;
    // trip only once the current source is running
    assign fault_trip = analog_status.sense_a_trip & blank_done_reg & gate_source_out;

    // Fault sequencer; a new trip only counts while idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_state_reg <= gate_drv_pkg::FLT_IDLE;
            mute_cnt_reg <= '0;
        end else if (clk_en) begin
            case (fault_state_reg)
                gate_drv_pkg::FLT_IDLE: begin
                    if (fault_trip) begin
                        fault_state_reg <= gate_drv_pkg::FLT_MUTE;
                        mute_cnt_reg <= '0;
                    end
                end
                gate_drv_pkg::FLT_MUTE: begin
                    if (mute_cnt_reg >= MUTE_LAST) begin
                        fault_state_reg <= gate_drv_pkg::FLT_WAIT_LOW;
                    end else begin
                        mute_cnt_reg <= mute_cnt_reg + 1'b1;
                    end
                end
                gate_drv_pkg::FLT_WAIT_LOW: begin
                    // low must also have lasted past the filter after mute
                    if (post_mute_low_reg >= RFIL_LAST) begin
                        fault_state_reg <= gate_drv_pkg::FLT_WAIT_RISE;
                    end
                end
                gate_drv_pkg::FLT_WAIT_RISE: begin
                    // release on the rising edge of enable
                    if (en_f) begin
                        fault_state_reg <= gate_drv_pkg::FLT_IDLE;
                    end
                end
                default: begin
                    fault_state_reg <= gate_drv_pkg::FLT_IDLE;
                end
            endcase
        end
    end

    // Enable low at mute end could have started during mute; the low count
    // is restarted so only lows that follow the mute qualify
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            post_mute_low_reg <= '0;
        end else if (clk_en) begin
            if (fault_state_reg != gate_drv_pkg::FLT_WAIT_LOW || en_f) begin
                post_mute_low_reg <= '0;
            end else if (post_mute_low_reg != {CW{1'b1}}) begin
                post_mute_low_reg <= post_mute_low_reg + 1'b1;
            end
        end
    end

    logic faulted;
    assign faulted = fault_state_reg != gate_drv_pkg::FLT_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Blanking after the source stage turns on

    logic [7:0] blank_cnt_reg;  // Cycles since the gate went high
    // blanking counter restarts on every turn-on
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blank_cnt_reg <= 8'h00;
            blank_done_reg <= 1'b0;
        end else if (clk_en) begin
            if (!gate_source_out) begin
                blank_cnt_reg <= 8'h00;
                blank_done_reg <= 1'b0;
            end else if (blank_cnt_reg >= BLANK_LAST) begin
                blank_done_reg <= 1'b1;
            end else begin
                blank_cnt_reg <= blank_cnt_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage, clamp, sense node and flags

    logic on_next;
    assign on_next = drive_on & ~faulted & ~fault_trip;

    // Registered pin drive
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gate_source_out <= 1'b0;
            gate_sink_out <= 1'b1;
            gate_ctrl <= '{source_on: 1'b0, sink_hard: 1'b1, sink_soft: 1'b0, hiz: 1'b0};
            miller_clamp_pin <= 1'b0;
            miller_clamp_pin_oe_n <= 1'b0;
            sense_a_pulldown <= 1'b1;
            sense_a_charge_en <= 1'b0;
        end else if (clk_en) begin
            // gate high only when all conditions hold
            gate_source_out <= on_next;
            gate_sink_out <= ~on_next & ~vdd_open_f;
            gate_ctrl.source_on <= on_next;
            // soft turn-off from the trip to the end of the mute interval
            gate_ctrl.sink_soft <= ~on_next & (fault_trip | fault_state_reg == gate_drv_pkg::FLT_MUTE);
            gate_ctrl.sink_hard <= ~on_next & ~vdd_open_f
                                   & ~(fault_trip | fault_state_reg == gate_drv_pkg::FLT_MUTE);
            // output stage released with no positive supply
            gate_ctrl.hiz <= vdd_open_f;
            // clamp when off and gate below threshold
            miller_clamp_pin <= ~on_next & analog_status.gate_below_clamp & rails_ok;
            miller_clamp_pin_oe_n <= on_next | vdd_open_f;
            // sense node held low whenever the gate is low
            sense_a_pulldown <= ~on_next;
            sense_a_charge_en <= on_next & blank_done_reg;
        end
    end

    // Open-drain flags: oe_n low means pulled low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_flag_n_o <= 1'b0;
            fault_flag_n_oe_n <= 1'b1;
            power_good_o <= 1'b0;
            power_good_oe_n <= 1'b0;
        end else if (clk_en) begin
            // flag low from trip until released
            fault_flag_n_oe_n <= ~(faulted | fault_trip);
            // power-good low in any supply fault
            power_good_oe_n <= rails_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog to PWM encoder

    localparam int unsigned SPAN_MV = gate_drv_pkg::AIN_MAX_MV - gate_drv_pkg::AIN_MIN_MV;
    localparam int unsigned SPAN_PM = gate_drv_pkg::DUTY_MAX_PERMILLE - gate_drv_pkg::DUTY_MIN_PERMILLE;
    localparam logic [12:0] MIN_MV = 13'(gate_drv_pkg::AIN_MIN_MV);
    localparam logic [12:0] MAX_MV = 13'(gate_drv_pkg::AIN_MAX_MV);

    logic [12:0] ain_clip;   // Input held within the encoder range
    logic [31:0] high_cyc;   // Cycles high in one period
    logic [11:0] enc_cnt_reg; // Position in the period
    logic [11:0] high_cyc_reg; // Duty latched at the period start
    assign ain_clip = (analog_sense_in < MIN_MV) ? MIN_MV : (analog_sense_in > MAX_MV) ? MAX_MV : analog_sense_in;
    // inverse linear map; a floating input clips to 10%
    assign high_cyc = ((gate_drv_pkg::DUTY_MAX_PERMILLE * SPAN_MV - 32'(ain_clip - MIN_MV) * SPAN_PM)
                       * gate_drv_pkg::ENC_PERIOD_CYC) / (SPAN_MV * gate_drv_pkg::PERMILLE_FULL);

    // Period counter; duty sampled once per period to avoid runt pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enc_cnt_reg <= 12'h000;
            high_cyc_reg <= 12'h000;
            encoded_pwm_out <= 1'b0;
            encoded_pwm_oe_n <= 1'b0;
        end else if (clk_en) begin
            // encoder stopped and low in lockout
            if (!rails_ok) begin
                enc_cnt_reg <= 12'h000;
                encoded_pwm_out <= 1'b0;
            end else begin
                enc_cnt_reg <= (enc_cnt_reg >= ENC_LAST) ? 12'h000 : enc_cnt_reg + 12'h001;
                if (enc_cnt_reg == 12'h000) begin
                    high_cyc_reg <= high_cyc[11:0];
                end
                encoded_pwm_out <= enc_cnt_reg < high_cyc_reg;
            end
            // output released with no positive supply
            encoded_pwm_oe_n <= vdd_open_f;
        end
    end

endmodule : gate_drv_logic

// ==== dv/gate_drv_monitor.sv ====
`timescale 1ns/1ps
module gate_drv_monitor #(
    parameter int unsigned FAULT_MUTE_CYC = 8,
    parameter int unsigned RESET_FILTER_CYC = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pwm_noninv_in,
    input wire logic pwm_inv_in,
    input wire logic reset_enable_in,
    input wire gate_drv_pkg::analog_status_t analog_status,
    input wire gate_drv_pkg::gate_ctrl_t gate_ctrl,
    input wire logic gate_source_out,
    input wire logic gate_sink_out,
    input wire logic miller_clamp_pin,
    input wire logic miller_clamp_pin_oe_n,
    input wire logic sense_a_charge_en,
    input wire logic fault_flag_n_oe_n,
    input wire logic power_good_oe_n,
    input wire logic encoded_pwm_out
);
    ////////////////////////////////////////
    // Any lockout or open rail
    logic lk;
    // Inputs that forbid turn-on
    logic bad;
    // Saturating run lengths
    logic [7:0] lk_cnt, bad_cnt, good_cnt, on_cnt, flt_cnt;
    assign lk = |analog_status[5:2];
    assign bad = pwm_inv_in | ~pwm_noninv_in | ~reset_enable_in;
    // Count up while cond holds, stick at the top
    function automatic logic [7:0] sat8(input logic [7:0] c, input logic cond);
        return cond ? ((c == 8'hFF) ? c : c + 8'h01) : 8'h00;
    endfunction : sat8
    // Run lengths restart on reset
    always_ff @(posedge clk) begin
        lk_cnt <= sys_rst ? 8'h00 : sat8(lk_cnt, lk);
        bad_cnt <= sys_rst ? 8'h00 : sat8(bad_cnt, bad);
        good_cnt <= sys_rst ? 8'h00 : sat8(good_cnt, ~bad & ~lk);
        on_cnt <= sys_rst ? 8'h00 : sat8(on_cnt, gate_source_out);
        flt_cnt <= sys_rst ? 8'h00 : sat8(flt_cnt, ~fault_flag_n_oe_n);
    end
    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_lockout_gate_off: assert property (lk_cnt >= 20 |-> !gate_source_out)
        else $error("gate on in lockout");
    a_lockout_ready_low: assert property (lk_cnt >= 20 |-> !power_good_oe_n)
        else $error("ready released in lockout");
    a_lockout_pwm_low: assert property (lk_cnt >= 20 |-> !encoded_pwm_out)
        else $error("encoder runs in lockout");
    a_clamp_off_on: assert property (gate_source_out |-> miller_clamp_pin_oe_n && !gate_sink_out)
        else $error("clamp or sink while on");
    a_charge_only_on: assert property (sense_a_charge_en |-> gate_source_out)
        else $error("charge while off");
    a_blank_early: assert property (sense_a_charge_en |-> on_cnt >= 50)
        else $error("charge before blanking");
    a_blank_late: assert property (on_cnt == 60 |-> sense_a_charge_en)
        else $error("charge missing after blanking");
    a_trip_soft_off: assert property (sense_a_charge_en && analog_status.sense_a_trip |-> ##[1:2]
        !gate_source_out && gate_ctrl.sink_soft && !fault_flag_n_oe_n)
        else $error("no soft turn-off on trip");
    a_fault_keeps_off: assert property (!fault_flag_n_oe_n |-> !gate_source_out)
        else $error("gate on while fault latched");
    a_mute_release: assert property ($rose(fault_flag_n_oe_n) |->
        flt_cnt >= FAULT_MUTE_CYC + RESET_FILTER_CYC)
        else $error("fault released too early");
    a_input_interlock: assert property (bad_cnt >= 14 |-> !gate_source_out)
        else $error("gate on with forbidding inputs");
    a_glitch_filter: assert property ($rose(gate_source_out) |-> good_cnt >= 10)
        else $error("short pulse reached gate");
endmodule : gate_drv_monitor

bind gate_drv_logic gate_drv_monitor #(
    .FAULT_MUTE_CYC(FAULT_MUTE_CYC),
    .RESET_FILTER_CYC(RESET_FILTER_CYC)
) u_mon (.clk, .sys_rst, .pwm_noninv_in, .pwm_inv_in, .reset_enable_in, .analog_status,
    .gate_ctrl, .gate_source_out, .gate_sink_out, .miller_clamp_pin, .miller_clamp_pin_oe_n,
    .sense_a_charge_en, .fault_flag_n_oe_n, .power_good_oe_n, .encoded_pwm_out);

// ==== dv/gate_drv_host_model.sv ====
`timescale 1ns/1ps
module gate_drv_host_model (
    input wire logic req_noninv,
    input wire logic req_inv,
    input wire logic req_enable,
    input wire logic fault_flag_n_o,
    input wire logic fault_flag_n_oe_n,
    input wire logic power_good_o,
    input wire logic power_good_oe_n,
    output logic pwm_noninv_in,
    output logic pwm_inv_in,
    output logic reset_enable_in,
    output logic fault_line,
    output logic ready_line
);
    // Controller pins follow its requests
    assign pwm_noninv_in = req_noninv;
    assign pwm_inv_in = req_inv;
    assign reset_enable_in = req_enable;
    // Open-drain flags: board pull-ups win when released
    assign fault_line = fault_flag_n_oe_n ? 1'b1 : fault_flag_n_o;
    assign ready_line = power_good_oe_n ? 1'b1 : power_good_o;
endmodule : gate_drv_host_model

// ==== dv/gate_drv_logic_tb.sv ====
`timescale 1ns/1ps
module gate_drv_logic_tb;
    logic clk, sys_rst, in_p, in_m, en, flt_l, rdy_l;
    logic pwm_noninv_in, pwm_inv_in, reset_enable_in;
    gate_drv_pkg::analog_status_t analog_status;
    logic [gate_drv_pkg::AIN_W-1:0] analog_sense_in;
    gate_drv_pkg::gate_ctrl_t gate_ctrl;
    logic gate_source_out, gate_sink_out, miller_clamp_pin, miller_clamp_pin_oe_n;
    logic sense_a_pulldown, sense_a_charge_en, fault_flag_n_o, fault_flag_n_oe_n;
    logic power_good_o, power_good_oe_n, encoded_pwm_out, encoded_pwm_oe_n;
    int num_errors, n_compared, k, hi, per, mv;
    int cyc = 0;
    ////////////////////////////////////////
    // Short mute and filter keep fault runs brief
    gate_drv_logic #(.FAULT_MUTE_CYC(40), .RESET_FILTER_CYC(20)) u_dut (.clk, .sys_rst,
        .clk_en(1'b1), .pwm_noninv_in, .pwm_inv_in, .reset_enable_in, .analog_status,
        .analog_sense_in, .gate_ctrl, .gate_source_out, .gate_sink_out, .miller_clamp_pin,
        .miller_clamp_pin_oe_n, .sense_a_pulldown, .sense_a_charge_en, .fault_flag_n_o,
        .fault_flag_n_oe_n, .power_good_o, .power_good_oe_n, .encoded_pwm_out, .encoded_pwm_oe_n);
    gate_drv_host_model u_host (.req_noninv(in_p), .req_inv(in_m), .req_enable(en),
        .fault_flag_n_o, .fault_flag_n_oe_n, .power_good_o, .power_good_oe_n, .pwm_noninv_in,
        .pwm_inv_in, .reset_enable_in, .fault_line(flt_l), .ready_line(rdy_l));
    ////////////////////////////////////////
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            end_sim();
        end
    end
    // Verdict and stop
    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Inputs move on falling edges only
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Bounded wait for the gate level
    task automatic wait_src(input logic v);
        k = 0;
        while (gate_source_out !== v && k < 20) @(negedge clk) k++;
    endtask : wait_src
    // High and full length of one encoder period
    task automatic meas();
        k = 0;
        while (encoded_pwm_out !== 1'b0 && k < 700) @(negedge clk) k++;
        while (encoded_pwm_out !== 1'b1 && k < 1400) @(negedge clk) k++;
        hi = 0;
        per = 0;
        while (encoded_pwm_out === 1'b1 && per < 700) @(negedge clk) hi++;
        per = hi;
        while (encoded_pwm_out !== 1'b1 && per < 700) @(negedge clk) per++;
    endtask : meas
    // Linear inverse map, clipped above the top of range
    function automatic int exp_hi(input int v);
        int c;
        c = (v > 4500) ? 4500 : v;
        return 625 * (880 - (c - 600) * 780 / 3900) / 1000;
    endfunction : exp_hi
    ////////////////////////////////////////
    initial begin
        num_errors = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        in_p = 1'b0;
        in_m = 1'b0;
        en = 1'b1;
        analog_status = '0;
        analog_sense_in = 13'h1388;
        k = $urandom(32'h760E);
        tick(8);
        sys_rst = 1'b0;
        tick(30);
        chk({rdy_l, flt_l}, 16'h0003);
        // Pulse shorter than the input filter
        in_p = 1'b1;
        tick(1 + $urandom % 8);
        in_p = 1'b0;
        tick(16);
        chk(gate_source_out, 16'h0000);
        in_p = 1'b1;
        wait_src(1'b1);
        chk({gate_source_out, miller_clamp_pin_oe_n}, 16'h0003);
        // Each lockout and open rail, then a short dip
        for (int b = 2; b < 6; b++) begin
            analog_status[b] = 1'b1;
            tick(24);
            chk({gate_source_out, rdy_l, encoded_pwm_out}, 16'h0000);
            if (b == 3) chk({gate_ctrl.hiz, encoded_pwm_oe_n}, 16'h0003);
            if (b == 2) chk(gate_sink_out, 16'h0001);
            analog_status[b] = 1'b0;
            tick(24);
            chk({gate_source_out, rdy_l}, 16'h0003);
        end
        analog_status.vdd_lockout = 1'b1;
        tick(8);
        analog_status.vdd_lockout = 1'b0;
        tick(4);
        chk({gate_source_out, rdy_l}, 16'h0003);
        // Both inputs high with the gate below threshold
        in_m = 1'b1;
        analog_status.gate_below_clamp = 1'b1;
        tick(16);
        chk({gate_source_out, miller_clamp_pin, miller_clamp_pin_oe_n}, 16'h0002);
        in_m = 1'b0;
        // Long enable low disables but flags stay released
        en = 1'b0;
        tick(30);
        chk({gate_ctrl.source_on, gate_ctrl.sink_hard, gate_source_out, gate_sink_out, sense_a_pulldown}, 16'h000B);
        chk({rdy_l, flt_l}, 16'h0003);
        en = 1'b1;
        wait_src(1'b1);
        k = 0;
        while (sense_a_charge_en !== 1'b1 && k < 80) @(negedge clk) k++;
        chk(k >= 48 && k <= 54, 16'h0001);
        analog_status.sense_a_trip = 1'b1;
        tick(2);
        chk({gate_source_out, gate_ctrl.sink_soft, flt_l}, 16'h0002);
        analog_status.sense_a_trip = 1'b0;
        // Reset attempt inside the mute interval is ignored
        en = 1'b0;
        tick(30);
        en = 1'b1;
        tick(30);
        chk({flt_l, gate_source_out}, 16'h0000);
        // long low after mute, release on the rise
        en = 1'b0;
        tick(30);
        chk(flt_l, 16'h0000);
        en = 1'b1;
        k = 0;
        while (flt_l !== 1'b1 && k < 20) @(negedge clk) k++;
        chk(flt_l, 16'h0001);
        // Encoder corners, floating input, then random levels
        for (int i = 0; i < 8; i++) begin
            mv = (i == 0) ? 600 : (i == 1) ? 4500 : (i == 2) ? 5000 : 600 + $urandom % 3901;
            analog_sense_in = 13'(mv);
            meas();
            meas();
            chk(16'(per), 16'h0271);
            chk(hi >= exp_hi(mv) - 2 && hi <= exp_hi(mv) + 2, 16'h0001);
        end
        end_sim();
    end
endmodule : gate_drv_logic_tb
